//--- qpd_pkg.sv
// Constants shared by the quad potentiometer command header decoder
`default_nettype none
package qpd_pkg;
    // Device type identifier; value is arbitrary
    localparam logic [3:0] QPD_DEV_TYPE = 4'h9;
    // Opcodes of the instruction byte
    localparam logic [3:0] OP_RD_STATUS = 4'h5;
    localparam logic [3:0] OP_WR_LATCH = 4'hA;
    localparam logic [3:0] OP_WR_SLOT = 4'hC;
    localparam logic [3:0] OP_SLOT_TO_LATCH = 4'hD;
    localparam logic [3:0] OP_LATCH_TO_SLOT = 4'hE;
    localparam logic [3:0] OP_GLB_SLOT_TO_LATCH = 4'h1;
    localparam logic [3:0] OP_GLB_LATCH_TO_SLOT = 4'h8;
    // Byte field positions
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int OPC_MSB = 7;
    localparam int OPC_LSB = 4;
    localparam int SLOT_MSB = 3;
    localparam int SLOT_LSB = 2;
    localparam int LATCH_MSB = 1;
    localparam int LATCH_LSB = 0;
    // Bit counts at byte boundaries and at the last bit of the frame
    localparam logic [4:0] BITS_HEADER = 5'h10;
    localparam logic [4:0] BITS_FRAME = 5'h18;
    localparam logic [4:0] BITS_LAST = 5'h17;
    // Reset contents
    localparam logic [7:0] SLOT_RESET_VALUE = 8'h80;
    localparam logic [7:0] TAP_RESET_VALUE = 8'h00;
    // Timing, system clock 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int NV_WRITE_CYCLE_TIME_NS = 5000000;
    localparam int NV_WRITE_CYC = NV_WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int WIPER_SETTLE_MIN_NS = 5000;
    localparam int WIPER_SETTLE_MAX_NS = 10000;
    localparam int WIPER_SETTLE_CYC =
        (WIPER_SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_WIPER_MIN_NS = 5000;
    localparam int POWERUP_WIPER_MAX_NS = 10000;
    localparam int POWERUP_WIPER_CYC =
        (POWERUP_WIPER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_READ_WAIT_NS = 1000000;
    // Core states
    typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_RUN} qpd_state_type;
endpackage
`default_nettype wire

//--- qpd_link_if.sv
// Header fields passed from the serial front end to the core
`default_nettype none
interface qpd_link_if;
    logic [7:0] addr_byte;
    logic [7:0] instr_byte;
    logic [7:0] data_byte;
    logic [4:0] bit_count;
    logic addr_match;
    logic frame_tog;
    logic [1:0] strap;
    logic pending;
    modport link (
        output addr_byte, instr_byte, data_byte, bit_count, addr_match,
        output frame_tog,
        input strap, pending
    );
    modport core (
        input addr_byte, instr_byte, data_byte, bit_count, addr_match,
        input frame_tog,
        output strap, pending
    );
endinterface
`default_nettype wire

//--- qpd_spi_front.sv
// Serial front end in the link clock domain: byte capture and address check
`default_nettype none
module qpd_spi_front import qpd_pkg::*; (
    // Link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // Reset
    input wire logic arst_n,
    // Core side
    qpd_link_if.link lnk
);
    logic frame_rst_n;
    logic active_reg;
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [6:0] sh_reg;
    logic [7:0] addr_reg;
    logic [7:0] instr_reg;
    logic [7:0] data_reg;
    logic match_reg;
    logic match_next;
    logic tog_reg;
    logic pend_s1_reg;
    logic pend_s2_reg;
    logic so_reg;
    wire [7:0] byte_in = {sh_reg, si};
    wire full = (count_reg == BITS_FRAME);
    wire byte_done = active_reg && !full && (count_next[2:0] == 3'h0);
    wire [1:0] byte_idx = count_reg[4:3];
    wire rd_status = (instr_reg[OPC_MSB:OPC_LSB] == OP_RD_STATUS);

    // Chip select high ends the frame without needing a link clock edge
    assign frame_rst_n = arst_n & ~cs_n;
    assign count_next = !active_reg ? 5'h01 :
                        (full ? count_reg : count_reg + 5'h01);
    assign match_next = (byte_in[TYPE_MSB:TYPE_LSB] == QPD_DEV_TYPE) &&
                        (byte_in[1:0] == lnk.strap);

    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= 1'b1;
        end
    end

    // Not cleared by chip select: the core reads these after the frame
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= 5'h00;
            sh_reg <= 7'h00;
            tog_reg <= 1'b0;
            pend_s1_reg <= 1'b0;
            pend_s2_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            sh_reg <= byte_in[6:0];
            tog_reg <= active_reg ? tog_reg : ~tog_reg;
            pend_s1_reg <= lnk.pending;
            pend_s2_reg <= pend_s1_reg;
        end
    end

    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            addr_reg <= 8'h00;
            match_reg <= 1'b0;
        end else if (!active_reg) begin
            match_reg <= 1'b0;
        end else if (byte_done && byte_idx == 2'h0) begin
            addr_reg <= byte_in;
            match_reg <= match_next;
        end
    end

    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            instr_reg <= 8'h00;
            data_reg <= 8'h00;
        end else if (byte_done && match_reg) begin
            if (byte_idx == 2'h1) begin
                instr_reg <= byte_in;
            end else if (byte_idx == 2'h2) begin
                data_reg <= byte_in;
            end
        end
    end

    // Status byte: only the last bit carries the pending flag
    always_ff @(negedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= (count_reg == BITS_LAST) && pend_s2_reg;
        end
    end

    // output stays off
    // Active gate: match and count still hold the last frame at select
    assign so_oe = !cs_n && active_reg && match_reg && rd_status &&
                   (count_reg >= BITS_HEADER);
    assign so_out = so_reg;
    assign lnk.addr_byte = addr_reg;
    assign lnk.instr_byte = instr_reg;
    assign lnk.data_byte = data_reg;
    assign lnk.bit_count = count_reg;
    assign lnk.addr_match = match_reg;
    assign lnk.frame_tog = tog_reg;
endmodule
`default_nettype wire

//--- qpd_header_decoder.sv
// Quad potentiometer command header decoder with setting store and timers
//
// Overview of operation
// - After chip select falls the first byte received is the address byte.
// - Upper four address bits must equal the fixed device type code.
// - Low two address bits must equal the sampled address strap inputs.
// - A device whose address differs does not execute the instruction.
// - Upper four bits of the second byte are the opcode.
// - Instruction bits 3:2 pick stored setting slot 0 to 3, binary coded.
// - Instruction bits 1:0 pick one of four wiper position latches.
// - A non-volatile write cycle completes within 5 ms.
// - Wiper reaches a new latch value 5 to 10 us after the change.
// - After power-up the wiper takes its position within 5 to 10 us.
// - At power-up each wiper latch loads from its own slot 0.
// - Non-volatile save begins when chip select returns high.
// - Write pending bit is 1 while a non-volatile write runs.
`default_nettype none
module qpd_header_decoder import qpd_pkg::*; #(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // Straps
    input wire logic [1:0] address_strap_inputs,
    // Wiper taps and status
    output logic [3:0][7:0] wiper_tap,
    output logic nv_write_pending
);
    qpd_link_if lnk ();

    qpd_state_type state_reg;
    qpd_state_type state_next;
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic [1:0] strap_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic seen_tog_reg;
    logic [3:0][7:0] latch_reg;
    logic [3:0][7:0] latch_next;
    logic [3:0][7:0] slot_wdata;
    logic [15:0] slot_we;
    logic [7:0] slot_reg [16];
    logic latch_chg;
    logic nv_start;
    logic [7:0] settle_reg;
    logic [15:0] nv_cnt_reg;
    logic pending_reg;
    logic [3:0][7:0] tap_reg;

    // Flat index of a slot of a given potentiometer
    function automatic logic [3:0] slot_idx(input logic [1:0] pot,
                                            input logic [1:0] slot);
        return {pot, slot};
    endfunction

    qpd_spi_front u_front (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .so_out(so_out),
        .so_oe(so_oe),
        .arst_n(arst_n),
        .lnk(lnk)
    );

    // Header fields; fields are stable once chip select is seen high
    wire [3:0] opcode_field = lnk.instr_byte[OPC_MSB:OPC_LSB];
    wire slot_select_high = lnk.instr_byte[SLOT_MSB];
    wire slot_select_low = lnk.instr_byte[SLOT_LSB];
    wire [1:0] slot_sel = {slot_select_high, slot_select_low};
    wire [1:0] latch_sel = lnk.instr_byte[LATCH_MSB:LATCH_LSB];
    wire frame_end = cs_s2_reg && !cs_s3_reg;
    wire has_data = (lnk.bit_count == BITS_FRAME);
    wire exec = frame_end && (state_reg == ST_RUN) &&
                (lnk.frame_tog != seen_tog_reg) && lnk.addr_match &&
                (lnk.bit_count >= BITS_HEADER);

    assign lnk.strap = strap_reg;
    assign lnk.pending = pending_reg;

    // Synchronisers for pins from outside this clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1_reg <= 2'h0;
            strap_s2_reg <= 2'h0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            strap_s1_reg <= address_strap_inputs;
            strap_s2_reg <= strap_s1_reg;
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    // Power-up sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: state_next = ST_WAIT;
            ST_WAIT: begin
                if (settle_reg == 8'h01) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_LOAD;
            strap_reg <= 2'h0;
            seen_tog_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_WAIT) begin
                strap_reg <= strap_s2_reg;
            end
            if (frame_end) begin
                seen_tog_reg <= lnk.frame_tog;
            end
        end
    end

    // Command execution; non-volatile writes refused while one runs
    always_comb begin
        latch_next = latch_reg;
        slot_we = 16'h0000;
        slot_wdata = latch_reg;
        latch_chg = 1'b0;
        nv_start = 1'b0;
        if (state_reg == ST_LOAD) begin
            for (int p = 0; p < 4; p++) begin
                latch_next[p] = slot_reg[slot_idx(2'(p), 2'h0)];
            end
            latch_chg = 1'b1;
        end else if (exec) begin
            case (opcode_field)
                OP_WR_LATCH: begin
                    if (has_data) begin
                        latch_next[latch_sel] = lnk.data_byte;
                        latch_chg = 1'b1;
                    end
                end
                OP_WR_SLOT: begin
                    if (has_data && !pending_reg) begin
                        slot_we[slot_idx(latch_sel, slot_sel)] = 1'b1;
                        slot_wdata[latch_sel] = lnk.data_byte;
                        nv_start = 1'b1;
                    end
                end
                OP_SLOT_TO_LATCH: begin
                    latch_next[latch_sel] =
                        slot_reg[slot_idx(latch_sel, slot_sel)];
                    latch_chg = 1'b1;
                end
                OP_LATCH_TO_SLOT: begin
                    if (!pending_reg) begin
                        slot_we[slot_idx(latch_sel, slot_sel)] = 1'b1;
                        nv_start = 1'b1;
                    end
                end
                OP_GLB_SLOT_TO_LATCH: begin
                    for (int p = 0; p < 4; p++) begin
                        latch_next[p] = slot_reg[slot_idx(2'(p), slot_sel)];
                    end
                    latch_chg = 1'b1;
                end
                OP_GLB_LATCH_TO_SLOT: begin
                    if (!pending_reg) begin
                        for (int p = 0; p < 4; p++) begin
                            slot_we[slot_idx(2'(p), slot_sel)] = 1'b1;
                        end
                        nv_start = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Setting store
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                slot_reg[i] <= SLOT_RESET_VALUE;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (slot_we[i]) begin
                    slot_reg[i] <= slot_wdata[i / 4];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= {4{SLOT_RESET_VALUE}};
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            settle_reg <= 8'h00;
            tap_reg <= {4{TAP_RESET_VALUE}};
        end else if (latch_chg) begin
            settle_reg <= (state_reg == ST_LOAD) ?
                          8'(POWERUP_WIPER_CYC) : 8'(WIPER_SETTLE_CYC);
        end else if (settle_reg != 8'h00) begin
            settle_reg <= settle_reg - 8'h01;
            if (settle_reg == 8'h01) begin
                tap_reg <= latch_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_cnt_reg <= 16'h0000;
            pending_reg <= 1'b0;
        end else begin
            if (nv_start) begin
                nv_cnt_reg <= 16'(NV_WRITE_CYCLES);
            end else if (nv_cnt_reg != 16'h0000) begin
                nv_cnt_reg <= nv_cnt_reg - 16'h0001;
            end
            pending_reg <= nv_start || (nv_cnt_reg > 16'h0001);
        end
    end

    assign wiper_tap = tap_reg;
    assign nv_write_pending = pending_reg;
endmodule
`default_nettype wire

//--- qpd_header_checker.sv
// Concurrent checks of the header decoder's top ports
`default_nettype none
module qpd_header_checker import qpd_pkg::*; #(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_out,
    input wire logic so_oe,
    // Straps, taps and status
    input wire logic [1:0] address_strap_inputs,
    input wire logic [3:0][7:0] wiper_tap,
    input wire logic nv_write_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    // Cycles since reset or since the last frame; saturate to stay valid
    logic [9:0] quiet_reg;
    logic [9:0] up_reg;
    logic [15:0] pend_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            quiet_reg <= 10'h000;
            up_reg <= 10'h000;
            pend_reg <= 16'h0000;
        end else begin
            quiet_reg <= cs_n ? quiet_reg + {9'h0, quiet_reg != 10'h3ff} : '0;
            up_reg <= up_reg + {9'h0, up_reg != 10'h3ff};
            pend_reg <= nv_write_pending ? pend_reg + 16'h0001 : '0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_pu_zero;
        (wiper_tap == {4{TAP_RESET_VALUE}}) [*8];
    endsequence
    sequence s_pu_recall;
        (wiper_tap == {4{SLOT_RESET_VALUE}}) [*4];
    endsequence
    a_tap_settle_window: assert property (
        $changed(wiper_tap) |-> quiet_reg inside {[10'h032:10'h06e]})
        else $error("wiper tap moved outside its settle window");
    a_pu_hold_zero: assert property (
        up_reg == 10'h002 |-> s_pu_zero)
        else $error("wiper tap moved too early after power-up");
    a_pu_slot_recall: assert property (
        up_reg == 10'h040 |-> s_pu_recall)
        else $error("wiper taps not recalled from slot 0");
    a_pend_max_len: assert property (
        nv_write_pending |-> pend_reg < NV_WRITE_CYCLES)
        else $error("write pending held too long");
    a_pend_min_hold: assert property (
        $rose(nv_write_pending) |=> nv_write_pending [*8])
        else $error("write pending dropped early");
    a_pend_after_cs: assert property (
        $rose(nv_write_pending) |-> $past(cs_n, 1) && $past(cs_n, 3))
        else $error("write started before chip select rose");
    a_oe_in_frame: assert property (
        so_oe |-> !cs_n && !$past(cs_n, 8))
        else $error("serial output driven outside a frame");
    a_pu_no_pend: assert property (
        up_reg < 10'h030 |-> !nv_write_pending)
        else $error("write pending without any write");
endmodule
`default_nettype wire

//--- qpd_host_model.sv
// Host side serial master model for the header decoder bench
`default_nettype none
module qpd_host_model (
    // Frame alignment
    input wire logic clk_sys,
    // Serial link
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] rx;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx = '0;
    end
    // address byte leads, all bytes MSB first; sck stops between frames
    task automatic frame(input logic [23:0] word, input int nbits);
        @(posedge clk_sys);
        #1 cs_n = 1'b0;
        #250;
        for (int i = 23; i > 23 - nbits; i--) begin
            si = word[i];
            #80 rx = {rx[22:0], so_oe ? so_out : 1'bx};
            sck = 1'b1;
            #80 sck = 1'b0;
        end
        #250 cs_n = 1'b1;
        // Released line must not look like held data
        si = ~si;
        #600;
    endtask
endmodule
`default_nettype wire

//--- qpd_header_decoder_tb.sv
// Self-checking bench for the quad potentiometer header decoder
`default_nettype none
module qpd_header_decoder_tb import qpd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NV = 200;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b1;
    logic [1:0] strap = 2'b01;
    logic sck, cs_n, si, so_out, so_oe, nv_write_pending;
    logic [3:0][7:0] wiper_tap;
    int mismatches = 0;
    int n_checks = 0;
    always #50 clk_sys = ~clk_sys;
    qpd_header_decoder #(.NV_WRITE_CYCLES(NV)) uut (.clk_sys(clk_sys),
        .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
        .so_oe(so_oe), .address_strap_inputs(strap), .wiper_tap(wiper_tap),
        .nv_write_pending(nv_write_pending));
    qpd_host_model host (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n),
        .si(si), .so_out(so_out), .so_oe(so_oe));
    task automatic report(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_tap(input int p, input logic [7:0] exp);
        report(wiper_tap[p], exp);
    endtask
    task automatic compare_status(input logic exp);
        report(host.rx[7:0], {7'h00, exp});
    endtask
    // middle address bits sent as zero
    task automatic cmd(input logic [1:0] a, input logic [7:0] ins, dat,
                       input int nbits);
        host.frame({QPD_DEV_TYPE, 2'b00, a, ins, dat}, nbits);
    endtask
    task automatic settle;
        repeat (70) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (nv_write_pending !== 1'b0 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 400) mismatches++;
    endtask
    task automatic status(input logic exp);
        cmd(strap, {OP_RD_STATUS, 4'b0001}, 8'h00, 24);
        compare_status(exp);
    endtask
    task automatic powerup;
        repeat (2) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        // host waits before its first command
        repeat (POWERUP_READ_WAIT_NS / CLK_PERIOD_NS) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #4_000_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        // Reset edge is needed: link side flops only see the async reset
        #1 arst_n = 1'b0;
        powerup();
        for (int p = 0; p < 4; p++) compare_tap(p, SLOT_RESET_VALUE);
        for (int p = 0; p < 4; p++) begin
            cmd(2'b01, {OP_WR_LATCH, 2'b00, p[1:0]}, 8'h30 + p[7:0], 24);
            settle();
            compare_tap(p, 8'h30 + p[7:0]);
        end
        cmd(2'b01, {OP_GLB_LATCH_TO_SLOT, 4'b1100}, 8'h00, 16);
        status(1'b1);
        wait_idle();
        status(1'b0);
        for (int s = 0; s < 4; s++) begin
            cmd(2'b01, {OP_WR_SLOT, s[1:0], 2'b01}, 8'h40 + s[7:0], 24);
            wait_idle();
        end
        cmd(2'b01, {OP_GLB_SLOT_TO_LATCH, 4'b1100}, 8'h00, 16);
        settle();
        for (int p = 0; p < 4; p++)
            compare_tap(p, p == 1 ? 8'h43 : 8'h30 + p[7:0]);
        for (int s = 0; s < 3; s++) begin
            cmd(2'b01, {OP_SLOT_TO_LATCH, s[1:0], 2'b01}, 8'h00, 16);
            settle();
            compare_tap(1, 8'h40 + s[7:0]);
        end
        cmd(2'b01, {OP_LATCH_TO_SLOT, 4'b0001}, 8'h00, 16);
        wait_idle();
        cmd(2'b01, {OP_GLB_SLOT_TO_LATCH, 4'b0000}, 8'h00, 16);
        settle();
        for (int p = 0; p < 4; p++)
            compare_tap(p, p == 1 ? 8'h42 : SLOT_RESET_VALUE);
        // Foreign strap and foreign device type must both be ignored
        cmd(2'b10, {OP_WR_LATCH, 4'b0000}, 8'h77, 24);
        host.frame({~QPD_DEV_TYPE, 4'b0001, OP_WR_LATCH, 4'h0, 8'h66},
                   24);
        settle();
        compare_tap(0, SLOT_RESET_VALUE);
        @(posedge clk_sys);
        #1 arst_n = 1'b0;
        strap = 2'b10;
        powerup();
        compare_tap(1, SLOT_RESET_VALUE);
        cmd(2'b10, {OP_WR_LATCH, 4'b0000}, 8'h77, 24);
        settle();
        compare_tap(0, 8'h77);
        end_of_test();
    end
endmodule
bind qpd_header_decoder qpd_header_checker #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (.clk_sys(clk_sys),
    .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe), .address_strap_inputs(address_strap_inputs),
    .wiper_tap(wiper_tap), .nv_write_pending(nv_write_pending));
`default_nettype wire
